// ---- arx_consts.vh ----
// constants for the eight-channel return-to-zero line receiver
// assumes a 32-bit AHB-Lite slave and one 50 MHz system clock
`ifndef ARX_CONSTS_VH
`define ARX_CONSTS_VH

`define ARX_CHANNELS      8
`define ARX_GAP_W         16
`define ARX_MSG_BITS      6'h20
`define ARX_CNT_SAT       6'h21

// byte offsets: per channel stride, in-channel offsets and global register offsets
`define ARX_CH_STRIDE     12'h010
`define ARX_OFS_CTRL      12'h000
`define ARX_OFS_GAP       12'h004
`define ARX_OFS_UPPER     12'h008
`define ARX_OFS_LOWER     12'h00C
`define ARX_OFS_STATUS    12'h080
`define ARX_OFS_INTEN     12'h084
`define ARX_OFS_SELFTEST  12'h088
`define ARX_OFS_VECTOR    12'h08C
`define ARX_LABEL_SEL     2'h1

// control register fields
`define ARX_CTL_ENABLE    15
`define ARX_CTL_TEST      14
`define ARX_CTL_LABEL_CHK 13
`define ARX_CTL_TABLE_WE  12
`define ARX_CTL_PAR_ODD   11
`define ARX_CTL_PAR_EN    10
`define ARX_CTL_WRONG_PAR 7
`define ARX_CTL_WMASK     16'hFC0F

// reset values
`define ARX_CTL_RESET     16'h0000
`define ARX_GAP_RESET     16'h0010
`define ARX_BUF_RESET     32'h0000_0000

`endif

// ---- arx_rx_channel.v ----
// one receive channel: bit clock recovery, shift register, gap counter
// lines arrive already synchronised; i_line_tick is a one-cycle pulse
`include "arx_consts.vh"

module arx_rx_channel (
	input  wire                  i_ref_clk,
	input  wire                  i_sys_rst,
	input  wire                  i_enable,
	input  wire                  i_line_high,
	input  wire                  i_line_low,
	input  wire                  i_line_tick,
	input  wire [`ARX_GAP_W-1:0] i_gap,
	output wire [31:0]           o_word,
	output wire [5:0]            o_bit_count,
	output wire                  o_eom,
	output wire                  o_new_msg
);
	reg                  prev_busy_ff;
	reg [31:0]           sr_ff;
	reg [5:0]            cnt_ff;
	reg [`ARX_GAP_W-1:0] gap_cnt_ff;
	reg                  gap_stop_ff;
	reg                  done_ff;
	reg                  eom_ff;

	// rebuilt bit clock: high while either line carries a pulse
	wire busy = i_line_high | i_line_low;
	wire rise = busy & ~prev_busy_ff;
	wire fall = ~busy & prev_busy_ff;
	wire [`ARX_GAP_W-1:0] nxt_gap_cnt = gap_cnt_ff + {{(`ARX_GAP_W-1){1'b0}}, 1'b1};

	assign o_word      = sr_ff;
	assign o_bit_count = cnt_ff;
	assign o_eom       = eom_ff;
	assign o_new_msg   = rise & done_ff;

	always @(posedge i_ref_clk) begin
		if (i_sys_rst || !i_enable) begin
			prev_busy_ff <= 1'b0;
			sr_ff        <= `ARX_BUF_RESET;
			cnt_ff       <= 6'h00;
			gap_cnt_ff   <= {`ARX_GAP_W{1'b0}};
			gap_stop_ff  <= 1'b1;
			done_ff      <= 1'b1;
			eom_ff       <= 1'b0;
		end else begin
			prev_busy_ff <= busy;
			eom_ff       <= 1'b0;
			if (rise) begin
				sr_ff   <= {i_line_high, sr_ff[31:1]};
				done_ff <= 1'b0;
				if (done_ff)
					cnt_ff <= 6'h01;
				else if (cnt_ff != `ARX_CNT_SAT)
					cnt_ff <= cnt_ff + 6'h01;
			end
			if (fall) begin
				gap_cnt_ff  <= {`ARX_GAP_W{1'b0}};
				gap_stop_ff <= 1'b0;
			end else if (i_line_tick && !gap_stop_ff) begin
				gap_cnt_ff <= nxt_gap_cnt;
				if (nxt_gap_cnt == i_gap) begin
					gap_stop_ff <= 1'b1;
					eom_ff      <= 1'b1;
					done_ff     <= 1'b1;
				end
			end
		end
	end
endmodule

// ---- arx_receiver.v ----
// eight-channel receiver with acceptance tables, buffers and AHB-Lite slave
// assumes a single-master AHB-Lite bus on i_ref_clk; line pins are asynchronous
`include "arx_consts.vh"

module arx_receiver (
	input  wire        i_ref_clk,
	input  wire        i_sys_rst,
	input  wire        i_hsel,
	input  wire [31:0] i_haddr,
	input  wire [1:0]  i_htrans,
	input  wire        i_hwrite,
	input  wire [2:0]  i_hsize,
	input  wire        i_hready,
	input  wire [31:0] i_hwdata,
	output wire [31:0] o_hrdata,
	output wire        o_hreadyout,
	output wire        o_hresp,
	input  wire        i_line_rate_clock,
	input  wire [7:0]  i_rx_line_high,
	input  wire [7:0]  i_rx_line_low,
	input  wire        i_tx3_line_high,
	input  wire        i_tx3_line_low,
	output wire        o_receive_interrupt_request,
	output wire [3:0]  o_irq_vector
);
	// address match of a per-channel register
	function ch_hit;
		input [11:0] a;
		input [2:0]  ch;
		input [11:0] ofs;
		begin
			ch_hit = (a == ({5'h00, ch, 4'h0} | ofs));
		end
	endfunction

	// synchronisers for pins and the line-rate clock
	reg [7:0] rxh_s1_ff;
	reg [7:0] rxh_s2_ff;
	reg [7:0] rxl_s1_ff;
	reg [7:0] rxl_s2_ff;
	reg       lclk_s1_ff;
	reg       lclk_s2_ff;
	reg       lclk_s3_ff;

	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			rxh_s1_ff  <= 8'h00;
			rxh_s2_ff  <= 8'h00;
			rxl_s1_ff  <= 8'h00;
			rxl_s2_ff  <= 8'h00;
			lclk_s1_ff <= 1'b0;
			lclk_s2_ff <= 1'b0;
			lclk_s3_ff <= 1'b0;
		end else begin
			rxh_s1_ff  <= i_rx_line_high;
			rxh_s2_ff  <= rxh_s1_ff;
			rxl_s1_ff  <= i_rx_line_low;
			rxl_s2_ff  <= rxl_s1_ff;
			lclk_s1_ff <= i_line_rate_clock;
			lclk_s2_ff <= lclk_s1_ff;
			lclk_s3_ff <= lclk_s2_ff;
		end
	end

	// one pulse per line-rate clock period
	wire line_tick = lclk_s2_ff & ~lclk_s3_ff;

	// bus slave: zero wait state, always OKAY
	reg        wr_pend_ff;
	reg [11:0] wr_addr_ff;
	reg [31:0] hrdata_ff;
	reg        hready_ff;
	reg        inten_ff;
	reg        selftest_ff;
	reg [3:0]  vector_ff;
	reg        irq_ff;
	reg [31:0] rd_mux;

	wire        ahb_take = i_hsel & i_htrans[1] & i_hready;
	wire        rd_take  = ahb_take & ~i_hwrite;
	wire [11:0] rd_addr  = i_haddr[11:0];

	assign o_hrdata                    = hrdata_ff;
	assign o_hreadyout                 = hready_ff;
	assign o_hresp                     = 1'b0;
	assign o_receive_interrupt_request = irq_ff;
	assign o_irq_vector                = vector_ff;

	// acceptance tables: one byte per label, one bit per channel
	reg [7:0] label_mem_ff [0:255];

	wire [7:0]   full_vec;
	wire [7:0]   wp_vec;
	wire [7:0]   twe_vec;
	wire [31:0]  prio_flat;
	wire [255:0] ch_rd_flat;

	genvar g;
	generate
		for (g = 0; g < `ARX_CHANNELS; g = g + 1) begin : g_ch
			reg [15:0]           ctrl_ff;
			reg [`ARX_GAP_W-1:0] gap_ff;
			reg [31:0]           buf_ff;
			reg                  full_ff;
			reg                  pend_ff;
			reg                  wp_ff;
			wire [31:0]          word;
			wire [5:0]           cnt;
			wire                 eom;
			wire                 new_msg;

			wire en = ctrl_ff[`ARX_CTL_ENABLE];
			// test path swaps in the third transmitter's lines
			wire lh = ctrl_ff[`ARX_CTL_TEST] ? i_tx3_line_high : rxh_s2_ff[g];
			wire ll = ctrl_ff[`ARX_CTL_TEST] ? i_tx3_line_low : rxl_s2_ff[g];

			arx_rx_channel u_chan (
				.i_ref_clk   (i_ref_clk),
				.i_sys_rst   (i_sys_rst),
				.i_enable    (en),
				.i_line_high (lh),
				.i_line_low  (ll),
				.i_line_tick (line_tick),
				.i_gap       (gap_ff),
				.o_word      (word),
				.o_bit_count (cnt),
				.o_eom       (eom),
				.o_new_msg   (new_msg)
			);

			wire [7:0] lbl    = word[7:0];
			wire       cnt_ok = (cnt == `ARX_MSG_BITS);
			wire       par_ok = ~ctrl_ff[`ARX_CTL_PAR_EN] |
				((^word) == ctrl_ff[`ARX_CTL_PAR_ODD]);
			wire       lab_ok = ~ctrl_ff[`ARX_CTL_LABEL_CHK] | label_mem_ff[lbl][g];
			wire       msg_ok = cnt_ok & par_ok & lab_ok;
			wire       par_bad_only = cnt_ok & lab_ok & ~par_ok;
			wire       xfer   = en & pend_ff & ~full_ff;
			wire       rel    = rd_take & ch_hit(rd_addr, g, `ARX_OFS_LOWER);
			wire       wr_ctl = wr_pend_ff & ch_hit(wr_addr_ff, g, `ARX_OFS_CTRL);
			wire       wr_gap = wr_pend_ff & ch_hit(wr_addr_ff, g, `ARX_OFS_GAP);

			always @(posedge i_ref_clk) begin
				if (i_sys_rst) begin
					ctrl_ff <= `ARX_CTL_RESET;
					gap_ff  <= `ARX_GAP_RESET;
					buf_ff  <= `ARX_BUF_RESET;
					full_ff <= 1'b0;
					pend_ff <= 1'b0;
					wp_ff   <= 1'b0;
				end else begin
					if (wr_ctl)
						ctrl_ff <= i_hwdata[15:0] & `ARX_CTL_WMASK;
					if (wr_gap)
						gap_ff <= i_hwdata[`ARX_GAP_W-1:0];
					// good message waits here until buffer frees or new bits arrive
					if (!en)
						pend_ff <= 1'b0;
					else if (eom && msg_ok)
						pend_ff <= 1'b1;
					else if (new_msg || xfer)
						pend_ff <= 1'b0;
					if (xfer) begin
						buf_ff  <= word;
						full_ff <= 1'b1;
					end else if (rel) begin
						full_ff <= 1'b0;
					end
					if (en && eom && par_bad_only && selftest_ff)
						wp_ff <= 1'b1;
					else if (wr_ctl && !i_hwdata[`ARX_CTL_WRONG_PAR])
						wp_ff <= 1'b0;
				end
			end

			assign full_vec[g]          = full_ff;
			assign wp_vec[g]            = wp_ff;
			assign twe_vec[g]           = ctrl_ff[`ARX_CTL_TABLE_WE];
			assign prio_flat[g*4 +: 4]  = ctrl_ff[3:0];
			// gap register reads as zero: write-only
			assign ch_rd_flat[g*32 +: 32] =
				ch_hit(rd_addr, g, `ARX_OFS_CTRL) ?
					{16'h0000, ctrl_ff[15:8], wp_ff, ctrl_ff[6:0]} :
				ch_hit(rd_addr, g, `ARX_OFS_UPPER) ? {16'h0000, buf_ff[31:16]} :
				ch_hit(rd_addr, g, `ARX_OFS_LOWER) ? {16'h0000, buf_ff[15:0]} :
				32'h0000_0000;
		end
	endgenerate

	// table writes only touch bits of channels in programming mode
	wire        tbl_wr  = wr_pend_ff & (wr_addr_ff[11:10] == `ARX_LABEL_SEL);
	wire [7:0]  tbl_idx = wr_addr_ff[9:2];

	always @(posedge i_ref_clk) begin
		if (tbl_wr)
			label_mem_ff[tbl_idx] <= (label_mem_ff[tbl_idx] & ~twe_vec) |
				(i_hwdata[7:0] & twe_vec);
	end

	// priority pick among channels with something pending
	wire [7:0] irq_src = full_vec | wp_vec;
	reg        best_found;
	reg [3:0]  best_prio;
	reg [2:0]  best_ch;
	integer    i;

	always @* begin
		best_found = 1'b0;
		best_prio  = 4'hF;
		best_ch    = 3'h0;
		for (i = 0; i < `ARX_CHANNELS; i = i + 1) begin
			if (irq_src[i] && (!best_found || prio_flat[i*4 +: 4] < best_prio)) begin
				best_found = 1'b1;
				best_prio  = prio_flat[i*4 +: 4];
				best_ch    = i[2:0];
			end
		end
	end

	always @* begin
		rd_mux = 32'h0000_0000;
		for (i = 0; i < `ARX_CHANNELS; i = i + 1)
			rd_mux = rd_mux | ch_rd_flat[i*32 +: 32];
		if (rd_addr == `ARX_OFS_STATUS)
			rd_mux = {16'h0000, wp_vec, full_vec};
		else if (rd_addr == `ARX_OFS_INTEN)
			rd_mux = {31'h0000_0000, inten_ff};
		else if (rd_addr == `ARX_OFS_SELFTEST)
			rd_mux = {31'h0000_0000, selftest_ff};
		else if (rd_addr == `ARX_OFS_VECTOR)
			rd_mux = {28'h000_0000, vector_ff};
		else if (rd_addr[11:10] == `ARX_LABEL_SEL)
			rd_mux = {24'h00_0000, label_mem_ff[rd_addr[9:2]]};
	end

	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			wr_pend_ff  <= 1'b0;
			wr_addr_ff  <= 12'h000;
			hrdata_ff   <= 32'h0000_0000;
			hready_ff   <= 1'b1;
			inten_ff    <= 1'b0;
			selftest_ff <= 1'b0;
			vector_ff   <= 4'h0;
			irq_ff      <= 1'b0;
		end else begin
			hready_ff  <= 1'b1;
			wr_pend_ff <= ahb_take & i_hwrite;
			if (ahb_take)
				wr_addr_ff <= i_haddr[11:0];
			// read data is captured in the address phase so it stands in the data phase
			if (rd_take)
				hrdata_ff <= rd_mux;
			if (wr_pend_ff && wr_addr_ff == `ARX_OFS_INTEN)
				inten_ff <= i_hwdata[0];
			if (wr_pend_ff && wr_addr_ff == `ARX_OFS_SELFTEST)
				selftest_ff <= i_hwdata[0];
			vector_ff <= {best_found, best_ch};
			irq_ff    <= inten_ff & best_found;
		end
	end
endmodule

// ---- arx_receiver_monitor.sv ----
// checker for the receiver's bus side, seen only through its top ports
// assumes one clock domain and a synchronous active-high reset
module arx_receiver_monitor (
	input wire logic        i_ref_clk,
	input wire logic        i_sys_rst,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic        i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic        o_receive_interrupt_request,
	input wire logic [3:0]  o_irq_vector
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	wire rd_ap = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
	sequence s_rd;
		rd_ap;
	endsequence
	sequence s_rd_gap;
		rd_ap && i_haddr[11:7] == 5'h0 && i_haddr[3:0] == 4'h4;
	endsequence
	sequence s_rd_ctl;
		rd_ap && i_haddr[11:7] == 5'h0 && i_haddr[3:0] == 4'h0;
	endsequence
	property p_okay;
		o_hresp == 1'b0 && o_hreadyout == 1'b1;
	endproperty
	property p_hi_zero;
		s_rd |=> o_hrdata[31:16] == 16'h0000;
	endproperty
	property p_gap_wo;
		s_rd_gap |=> o_hrdata == 32'h0000_0000;
	endproperty
	property p_ctl_rsv;
		s_rd_ctl |=> o_hrdata[9:8] == 2'h0 && o_hrdata[6:4] == 3'h0;
	endproperty
	// read data may only move when a read was taken
	property p_hold;
		!$past(rd_ap) && !$past(i_sys_rst) |-> $stable(o_hrdata);
	endproperty
	property p_irq_vec;
		o_receive_interrupt_request |-> o_irq_vector[3];
	endproperty
	property p_unmapped;
		s_rd ##0 (i_haddr[11:0] >= 12'h090 && i_haddr[11:0] < 12'h400) |=> o_hrdata == 32'h0000_0000;
	endproperty
	property p_rst;
		$fell(i_sys_rst) |-> o_hrdata == 32'h0000_0000 && !o_receive_interrupt_request
			&& o_irq_vector == 4'h0;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
	a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
	a_gap_wo: assert property (p_gap_wo) else $error("gap register readable");
	a_ctl_rsv: assert property (p_ctl_rsv) else $error("unused control bits set");
	a_hold: assert property (p_hold) else $error("read data moved without read");
	a_irq_vec: assert property (p_irq_vec) else $error("request without vector");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

bind arx_receiver arx_receiver_monitor u_mon (
	.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.o_receive_interrupt_request(o_receive_interrupt_request), .o_irq_vector(o_irq_vector)
);

// ---- arx_line_model.sv ----
// line side model: eight return-to-zero line pairs and the line-rate clock
// assumes the system clock as timebase; lines rest at null, both low
module arx_line_model (
	input  wire logic  i_ref_clk,
	output logic [7:0] o_line_high,
	output logic [7:0] o_line_low,
	output logic       o_line_rate_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_ff = 3'h0;
	initial begin
		o_line_high = 8'h00;
		o_line_low = 8'h00;
		o_line_rate_clock = 1'b0;
	end
	// free running, ten system cycles, well above the four-cycle floor
	always @(posedge i_ref_clk) begin
		div_ff <= (div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
		if (div_ff == 3'h4)
			o_line_rate_clock <= ~o_line_rate_clock;
	end
	// lsb first; len stretches the pulse for a slow sender
	task automatic send(input int ch, input logic [31:0] w, input int n, input int len);
		for (int i = 0; i < n; i++) begin
			@(posedge i_ref_clk);
			o_line_high[ch] <= w[i];
			o_line_low[ch] <= ~w[i];
			repeat (len) @(posedge i_ref_clk);
			o_line_high[ch] <= 1'b0;
			o_line_low[ch] <= 1'b0;
			repeat (4) @(posedge i_ref_clk);
		end
	endtask
endmodule

// ---- test_arx_receiver.sv ----
// self-checking bench for the eight-channel receiver
// assumes the line model as far side and a single bus master here
module test_arx_receiver;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwr = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hready;
	wire  [7:0]  lh;
	wire  [7:0]  ll;
	wire         lclk;
	wire         irq;
	wire  [3:0]  vec;
	int          fail_count = 0;
	int          cmp_count = 0;
	always #10 clk = ~clk;
	arx_receiver uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwr), .i_hsize(3'h2), .i_hready(hready),
		.i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
		.i_line_rate_clock(lclk), .i_rx_line_high(lh), .i_rx_line_low(ll),
		.i_tx3_line_high(1'b0), .i_tx3_line_low(1'b0),
		.o_receive_interrupt_request(irq), .o_irq_vector(vec));
	arx_line_model lm (.i_ref_clk(clk), .o_line_high(lh), .o_line_low(ll),
		.o_line_rate_clock(lclk));
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwr <= w;
		haddr <= {20'h0_0000, a};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		// a read taken in a write's data phase would still see the old value
		if (w)
			@(posedge clk);
	endtask
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(n, rd, e);
	endtask
	// bounded poll of the status word
	task automatic wait_st(input logic [15:0] m);
		for (int i = 0; i < 80; i++) begin
			xfer(1'b0, 12'h080, 32'h0000_0000);
			if ((rd[15:0] & m) === m)
				break;
		end
	endtask
	task automatic t_regs();
		rchk("ctrl reset", 12'h000, 32'h0000_0000);
		xfer(1'b1, 12'h020, 32'h0000_FFFF);
		rchk("ctrl mask", 12'h020, 32'h0000_FC0F);
		xfer(1'b1, 12'h024, 32'h0000_1234);
		rchk("gap", 12'h024, 32'h0000_0000);
		xfer(1'b1, 12'h008, 32'h0000_BEEF);
		rchk("upper ro", 12'h008, 32'h0000_0000);
		rchk("unmapped", 12'h200, 32'h0000_0000);
		xfer(1'b1, 12'h020, 32'h0000_0000);
	endtask
	task automatic t_msg();
		xfer(1'b1, 12'h084, 32'h0000_0001);
		xfer(1'b1, 12'h004, 32'h0000_0004);
		xfer(1'b1, 12'h034, 32'h0000_0004);
		xfer(1'b1, 12'h000, 32'h0000_8003);
		xfer(1'b1, 12'h030, 32'h0000_8001);
		lm.send(0, 32'hA5C3_1E77, 32, 5);
		wait_st(16'h0001);
		chk("irq", 32'(irq), 32'h1);
		// second message must wait behind the full buffer
		lm.send(0, 32'h0F0F_0001, 32, 8);
		repeat (80) @(posedge clk);
		rchk("upper", 12'h008, 32'h0000_A5C3);
		rchk("lower", 12'h00C, 32'h0000_1E77);
		repeat (4) @(posedge clk);
		lm.send(3, 32'h1234_5601, 32, 5);
		wait_st(16'h0009);
		chk("vector", 32'(vec), 32'hB);
		rchk("upper2", 12'h008, 32'h0000_0F0F);
		rchk("lower2", 12'h00C, 32'h0000_0001);
		rchk("upper3", 12'h038, 32'h0000_1234);
		rchk("lower3", 12'h03C, 32'h0000_5601);
		repeat (4) @(posedge clk);
		chk("irq off", 32'(irq), 32'h0);
	endtask
	task automatic drop(input logic [31:0] w, input int n, input logic [31:0] st);
		lm.send(0, w, n, 5);
		repeat (80) @(posedge clk);
		rchk("status", 12'h080, st);
	endtask
	task automatic t_bad();
		xfer(1'b1, 12'h088, 32'h0000_0001);
		xfer(1'b1, 12'h000, 32'h0000_8403);
		drop(32'h0000_0001, 32, 32'h0000_0100);
		rchk("flag", 12'h000, 32'h0000_8483);
		chk("irq flag", 32'(irq), 32'h1);
		xfer(1'b1, 12'h000, 32'h0000_8C03);
		rchk("flag clr", 12'h000, 32'h0000_8C03);
		lm.send(0, 32'h0000_0001, 32, 5);
		wait_st(16'h0001);
		rchk("odd up", 12'h008, 32'h0000_0000);
		rchk("odd low", 12'h00C, 32'h0000_0001);
		drop(32'h0000_0001, 31, 32'h0000_0000);
		xfer(1'b1, 12'h000, 32'h0000_9003);
		xfer(1'b1, 12'h5DC, 32'h0000_0001);
		xfer(1'b1, 12'h554, 32'h0000_0000);
		xfer(1'b1, 12'h000, 32'h0000_A003);
		drop(32'h0000_0055, 32, 32'h0000_0000);
		lm.send(0, 32'h0000_0077, 32, 5);
		wait_st(16'h0001);
		rchk("label up", 12'h008, 32'h0000_0000);
		rchk("label low", 12'h00C, 32'h0000_0077);
		xfer(1'b1, 12'h000, 32'h0000_0000);
		drop(32'h0000_0077, 32, 32'h0000_0000);
	endtask
	initial begin
		#1ms;
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_msg();
		t_bad();
		stop_test();
	end
endmodule
